// *** rtl/sst_pkg.sv ***
package sst_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned PIX_W   = 14;
   localparam int unsigned LINE_W  = 13;
   localparam int unsigned CNT_W   = 13;
   localparam int unsigned FLD_W   = 14;
   localparam int unsigned ADDR_W  = 10;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned HP_W    = 28;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_ACTION  = 8'h70;
   localparam logic [7:0] IDX_MASKS   = 8'h74;
   localparam logic [7:0] IDX_PCOUNT  = 8'h75;
   localparam logic [7:0] IDX_TOGGLE  = 8'h76;
   localparam logic [7:0] IDX_FINE    = 8'h77;
   localparam logic [7:0] IDX_CTRL    = 8'h78;
   localparam logic [7:0] IDX_DELAY   = 8'h79;
   localparam logic [7:0] IDX_GLINE   = 8'h7a;
   localparam logic [7:0] IDX_STATUS  = 8'h7b;

   // field positions inside the data word
   localparam int unsigned LO_LSB  = 0;
   localparam int unsigned HI_LSB  = 16;
   localparam int unsigned POL_BIT = 0;
   localparam int unsigned SKIP_BIT = 1;
   localparam int unsigned STAT_GATE_BIT = 29;
   localparam int unsigned STAT_SUB_BIT  = 30;
   localparam int unsigned STAT_RUN_BIT  = 31;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] ACT_IDLE   = 3'h0;
   localparam logic [2:0] ACT_SINGLE = 3'h1;
   localparam logic [2:0] ACT_REPEAT = 3'h2;
   localparam logic [HP_W-1:0]   HP_OFF       = 28'hfffffff;
   localparam logic [CNT_W-1:0]  PCOUNT_RESET = 13'h0001;
   localparam logic [1:0] LVL_HIGH    = 2'h0;
   localparam logic [1:0] LVL_MID_LOW = 2'h1;
   localparam logic [1:0] LVL_LOWEST  = 2'h2;

   typedef enum logic [2:0] {
      SST_IDLE  = 3'b001,
      SST_ARMED = 3'b010,
      SST_RUN   = 3'b100
   } sst_fsm_t;

   typedef struct packed {
      sst_fsm_t          fsm;
      logic [2:0]        action;
      logic [CNT_W-1:0]  gmask;
      logic [CNT_W-1:0]  smask;
      logic              skip;
      logic [CNT_W-1:0]  cnt_w;
      logic [LINE_W-1:0] dly_w;
      logic              pol_w;
      logic [PIX_W-1:0]  t1_w;
      logic [PIX_W-1:0]  t2_w;
      logic [HP_W-1:0]   hp;
      logic [LINE_W-1:0] gate_line;
      logic              pol;
      logic [PIX_W-1:0]  t1;
      logic [PIX_W-1:0]  t2;
      logic [CNT_W-1:0]  cnt;
      logic [LINE_W-1:0] dly;
      logic [PIX_W-1:0]  pix;
      logic [LINE_W-1:0] lc;
      logic [CNT_W-1:0]  done;
      logic [FLD_W-1:0]  fld;
      logic              pline;
      logic              last;
      logic              sub_o;
      logic              sg_o;
      logic [1:0]        lvl;
      logic [DATA_W-1:0] rdata;
   } sst_state_t;
endpackage

// *** rtl/sst_shutter.sv ***
// Summary of operation
// (R1) driver input low gives high level; high selects mid-low or lowest by level select input.
// (R2) shutter output is one pulse per line, programmable width, placement, count.
// (R3) normal mode by default: the pulse train repeats in every field.
// (R4) polarity from control register, toggles from toggle register, pulse count from its own register.
// (R5) pulses start in the line after the gate active line.
// (R6) shutter settings take effect at the start of the line after the gate line; the fine toggles are not shadowed and take effect at once.
// (R7) high-precision mode adds an extra pulse in the last pulsed line.
// (R8) extra pulse suppressed while its toggle register holds all ones.
// (R9) software picks normal or fine below one field, long mode above.
// (R10) long exposure starts only after software activates the field counter.
// (R11) gate and substrate masks last the programmed field counts.
// (R12) field after the action write is the first masked field.
// (R13) skip bit ignores the first masks, exposure starts a field later.
// (R14) software may delay mask start with a delay register instead; here only the skip bit delays it, by one field.
// (R15) zero mask counts leave outputs as in normal operation.
// (R16) a secondary counter never touches substrate or gate outputs.
// (R17) start delay pushes first pulse that many lines later.
// (R18) mask counts 13 bit, pulse count 13 bit, toggles 14 bit.
// (R19) action 0 idle, 1 single run then idle, 2 repeating run.
// (R20) after the last pulse the output holds start polarity until next field.
module sst_shutter #(
   parameter int unsigned PIX_W  = 14,
   parameter int unsigned LINE_W = 13,
   parameter int unsigned CNT_W  = 13
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       clk_en_i,
   input  wire logic                       line_sync_i,
   input  wire logic                       field_sync_i,
   input  wire logic                       sense_gate_req_i,
   input  wire logic                       substrate_driver_input_i,
   input  wire logic                       substrate_level_select_input_i,
   input  wire logic [sst_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [sst_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [sst_pkg::DATA_W-1:0] reg_rdata_o,
   output logic                            substrate_shutter_pulse_o,
   output logic                            sense_gate_pulse_o,
   output logic      [1:0]                 substrate_level_o
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (PIX_W != sst_pkg::PIX_W || LINE_W != sst_pkg::LINE_W || CNT_W != sst_pkg::CNT_W) begin
      $error("widths must match the package state layout");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic hit_f(input logic [sst_pkg::ADDR_W-1:0] a,
                                  input logic [7:0] idx);
      hit_f = (a == {idx, 2'b00});
   endfunction

   // level starts at polarity, flips at first toggle, flips back at second
   function automatic logic win_f(input logic [sst_pkg::PIX_W-1:0] p,
                                  input logic [sst_pkg::PIX_W-1:0] a,
                                  input logic [sst_pkg::PIX_W-1:0] b);
      win_f = (p >= a) && (p < b);
   endfunction

   function automatic logic [1:0] lvl_f(input logic drv, input logic sel);
      if (!drv) begin
         lvl_f = sst_pkg::LVL_HIGH;
      end else if (!sel) begin
         lvl_f = sst_pkg::LVL_MID_LOW;
      end else begin
         lvl_f = sst_pkg::LVL_LOWEST;
      end
   endfunction

   // masked for fields 1..n of the run, one field later when skipping
   function automatic logic mask_f(input logic [sst_pkg::FLD_W-1:0] f,
                                   input logic skip,
                                   input logic [sst_pkg::CNT_W-1:0] n);
      logic [sst_pkg::FLD_W-1:0] e;
      e = skip ? f - 14'h0001 : f;
      mask_f = (e != 14'h0000) && (e <= {1'b0, n});
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sst_pkg::sst_state_t st;
   sst_pkg::sst_state_t next_st;

   logic                      wr_action;
   logic                      upd;
   logic                      gate_mask;
   logic                      sub_mask;
   logic [sst_pkg::FLD_W-1:0] run_len;
   logic [LINE_W:0]           start_line;
   logic [LINE_W-1:0]         lc_n;
   logic                      extra_on;

   always_comb begin
      wr_action = reg_wr_i && hit_f(reg_addr_i, sst_pkg::IDX_ACTION);
      // masks only while the field counter is running
      gate_mask = (st.fsm == sst_pkg::SST_RUN) && mask_f(st.fld, st.skip, st.gmask); // R11 R13
      sub_mask  = (st.fsm == sst_pkg::SST_RUN) && mask_f(st.fld, st.skip, st.smask); // R11 R13
      run_len   = ((st.gmask > st.smask) ? {1'b0, st.gmask} : {1'b0, st.smask})
                  + {13'h0000, st.skip};
      lc_n      = field_sync_i ? '0 : st.lc + 13'h0001;
      upd       = line_sync_i && !field_sync_i && (lc_n == st.gate_line + 13'h0001); // R6
      extra_on  = (st.hp != sst_pkg::HP_OFF);                                        // R8
      start_line = {1'b0, st.gate_line} + 14'h0001
                 + {1'b0, (upd ? st.dly_w : st.dly)};                                // R5 R17
   end

   always_comb begin
      next_st = st;
      // -------------------------------------------------------------
      // register writes
      // -------------------------------------------------------------
      if (reg_wr_i) begin
         if (hit_f(reg_addr_i, sst_pkg::IDX_MASKS)) begin
            next_st.gmask = reg_wdata_i[sst_pkg::LO_LSB +: CNT_W];             // R18
            next_st.smask = reg_wdata_i[sst_pkg::HI_LSB +: CNT_W];             // R18
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_PCOUNT)) begin
            next_st.cnt_w = reg_wdata_i[sst_pkg::LO_LSB +: CNT_W];             // R4
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_TOGGLE)) begin
            next_st.t1_w = reg_wdata_i[sst_pkg::LO_LSB +: PIX_W];              // R4
            next_st.t2_w = reg_wdata_i[sst_pkg::HI_LSB +: PIX_W];
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_FINE)) begin
            next_st.hp = reg_wdata_i[sst_pkg::HP_W-1:0];
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_CTRL)) begin
            next_st.pol_w = reg_wdata_i[sst_pkg::POL_BIT];
            next_st.skip  = reg_wdata_i[sst_pkg::SKIP_BIT];
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_DELAY)) begin
            next_st.dly_w = reg_wdata_i[sst_pkg::LO_LSB +: LINE_W];
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_GLINE)) begin
            next_st.gate_line = reg_wdata_i[sst_pkg::LO_LSB +: LINE_W];
         end
      end

      // -------------------------------------------------------------
      // field counter
      // -------------------------------------------------------------
      if (field_sync_i) begin
         case (st.fsm)
            sst_pkg::SST_IDLE: begin
               next_st.fsm = sst_pkg::SST_IDLE;
            end
            sst_pkg::SST_ARMED: begin
               next_st.fsm = sst_pkg::SST_RUN;                                 // R12
               next_st.fld = 14'h0001;
            end
            sst_pkg::SST_RUN: begin
               if (st.fld >= run_len) begin
                  if (st.action == sst_pkg::ACT_REPEAT) begin
                     next_st.fld = 14'h0001;                                   // R19
                  end else begin
                     next_st.fsm = sst_pkg::SST_IDLE;                          // R19
                     next_st.fld = '0;
                  end
               end else begin
                  next_st.fld = st.fld + 14'h0001;
               end
            end
            default: begin
               next_st.fsm = sst_pkg::SST_IDLE;
            end
         endcase
      end
      // a write arriving with the field edge still arms the run
      if (wr_action) begin
         next_st.action = reg_wdata_i[2:0];
         if (reg_wdata_i[2:0] == sst_pkg::ACT_SINGLE ||
             reg_wdata_i[2:0] == sst_pkg::ACT_REPEAT) begin
            next_st.fsm = sst_pkg::SST_ARMED;                                  // R10
         end else begin
            next_st.fsm = sst_pkg::SST_IDLE;                                   // R19
         end
         next_st.fld = '0;
      end

      // -------------------------------------------------------------
      // line and pixel position, shadow copies
      // -------------------------------------------------------------
      next_st.pix = line_sync_i ? '0 : ((&st.pix) ? st.pix : st.pix + 14'h0001);
      if (line_sync_i) begin
         next_st.lc = lc_n;
         if (upd) begin
            next_st.pol = st.pol_w;                                            // R6
            next_st.t1  = st.t1_w;
            next_st.t2  = st.t2_w;
            next_st.cnt = st.cnt_w;
            next_st.dly = st.dly_w;
         end
         if (field_sync_i) begin
            next_st.done  = '0;                                                // R3
            next_st.pline = 1'b0;
            next_st.last  = 1'b0;
         end else if (({1'b0, lc_n} >= start_line) && (st.done < next_st.cnt)
                      && !sub_mask) begin
            next_st.pline = 1'b1;                                              // R2
            next_st.done  = st.done + 13'h0001;
            next_st.last  = (st.done + 13'h0001 == next_st.cnt);               // R7
         end else begin
            next_st.pline = 1'b0;                                              // R20
            next_st.last  = 1'b0;
         end
      end

      // -------------------------------------------------------------
      // outputs; no secondary counter term reaches them
      // -------------------------------------------------------------
      next_st.sub_o = st.pol ^ (st.pline && (win_f(st.pix, st.t1, st.t2) ^
                      (st.last && extra_on &&
                       win_f(st.pix, st.hp[PIX_W-1:0], st.hp[sst_pkg::HP_W-1:PIX_W])))); // R7 R8 R16
      next_st.sg_o  = sense_gate_req_i && !gate_mask;                          // R11 R15 R16
      next_st.lvl   = lvl_f(substrate_driver_input_i, substrate_level_select_input_i); // R1

      // -------------------------------------------------------------
      // read port, data valid only the cycle after the strobe
      // -------------------------------------------------------------
      next_st.rdata = '0;
      if (reg_rd_i) begin
         if (hit_f(reg_addr_i, sst_pkg::IDX_ACTION)) begin
            next_st.rdata[2:0] = st.action;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_MASKS)) begin
            next_st.rdata[sst_pkg::LO_LSB +: CNT_W] = st.gmask;
            next_st.rdata[sst_pkg::HI_LSB +: CNT_W] = st.smask;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_PCOUNT)) begin
            next_st.rdata[sst_pkg::LO_LSB +: CNT_W] = st.cnt_w;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_TOGGLE)) begin
            next_st.rdata[sst_pkg::LO_LSB +: PIX_W] = st.t1_w;
            next_st.rdata[sst_pkg::HI_LSB +: PIX_W] = st.t2_w;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_FINE)) begin
            next_st.rdata[sst_pkg::HP_W-1:0] = st.hp;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_CTRL)) begin
            next_st.rdata[sst_pkg::POL_BIT]  = st.pol_w;
            next_st.rdata[sst_pkg::SKIP_BIT] = st.skip;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_DELAY)) begin
            next_st.rdata[sst_pkg::LO_LSB +: LINE_W] = st.dly_w;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_GLINE)) begin
            next_st.rdata[sst_pkg::LO_LSB +: LINE_W] = st.gate_line;
         end
         if (hit_f(reg_addr_i, sst_pkg::IDX_STATUS)) begin
            next_st.rdata[sst_pkg::LO_LSB +: sst_pkg::FLD_W] = st.fld;
            next_st.rdata[sst_pkg::HI_LSB +: CNT_W]          = st.done;
            next_st.rdata[sst_pkg::STAT_GATE_BIT] = gate_mask;
            next_st.rdata[sst_pkg::STAT_SUB_BIT]  = sub_mask;
            next_st.rdata[sst_pkg::STAT_RUN_BIT]  = (st.fsm == sst_pkg::SST_RUN);
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st           <= '0;
         st.fsm       <= sst_pkg::SST_IDLE;
         st.action    <= sst_pkg::ACT_IDLE;
         st.cnt_w     <= sst_pkg::PCOUNT_RESET;
         st.cnt       <= sst_pkg::PCOUNT_RESET;
         st.hp        <= sst_pkg::HP_OFF;                                      // R8
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   assign reg_rdata_o               = st.rdata;
   assign substrate_shutter_pulse_o = st.sub_o;
   assign sense_gate_pulse_o        = st.sg_o;
   assign substrate_level_o         = st.lvl;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_level_map: assert property ($past(rst_n_i) && $past(clk_en_i) |-> // R1
      st.lvl == lvl_f($past(substrate_driver_input_i), $past(substrate_level_select_input_i)))
      else $error("substrate level does not follow driver inputs");
   a_pulse_bound: assert property (st.done <= st.cnt) // R2
      else $error("more pulse lines than programmed");
   a_idle_hold: assert property ($past(rst_n_i) && $past(clk_en_i && !st.pline) |-> // R20
      st.sub_o == $past(st.pol))
      else $error("shutter output left start level outside pulse line");
   a_shadow_load: assert property ($past(rst_n_i) && $changed(st.cnt) |-> // R6
      $past(upd && clk_en_i))
      else $error("pulse count changed outside update line");
   a_fine_off: assert property ($past(rst_n_i) && $past(clk_en_i && st.hp == sst_pkg::HP_OFF) // R8
      |-> st.sub_o == $past(st.pol ^ (st.pline && win_f(st.pix, st.t1, st.t2))))
      else $error("extra pulse while fine toggles at all ones");
   a_arm_run: assert property (st.fsm == sst_pkg::SST_ARMED && field_sync_i && clk_en_i // R12
      && !wr_action |=> st.fsm == sst_pkg::SST_RUN && st.fld == 14'h0001)
      else $error("run did not start at next field");
   a_zero_mask: assert property ($past(rst_n_i) && $past(clk_en_i && st.gmask == '0) // R15
      |-> st.sg_o == $past(sense_gate_req_i))
      else $error("gate masked with zero mask count");
   a_first_pulse: assert property ($rose(st.pline) && $past(st.done == '0) |-> // R5
      {1'b0, st.lc} >= {1'b0, st.gate_line} + 14'h0001 + {1'b0, st.dly})
      else $error("pulse before gate line plus delay");
   a_single_end: assert property (st.fsm == sst_pkg::SST_RUN && st.action == sst_pkg::ACT_SINGLE // R19
      && st.fld >= run_len && field_sync_i && clk_en_i && !wr_action |=> st.fsm == sst_pkg::SST_IDLE)
      else $error("single run did not return to idle");
   a_ls_mask: assert property (st.fsm == sst_pkg::SST_IDLE && clk_en_i |=> // R10
      st.sg_o == $past(sense_gate_req_i))
      else $error("gate masked without active field counter");
   a_gate_mask: assert property ($past(clk_en_i && gate_mask) |-> // R11
      !st.sg_o)
      else $error("gate pulse passed while masked");
   a_sub_mask: assert property (sub_mask && line_sync_i && clk_en_i |=> // R11
      !st.pline)
      else $error("pulse line chosen while substrate masked");
   a_field_clear: assert property (field_sync_i && line_sync_i && clk_en_i |=> // R3
      st.done == '0 && !st.pline)
      else $error("pulse tally not cleared at field start");
   a_skip_first: assert property (st.fsm == sst_pkg::SST_RUN && st.skip && // R13
      st.fld == 14'h0001 |-> !gate_mask && !sub_mask)
      else $error("first run field masked with skip set");
   a_idle_write: assert property (wr_action && clk_en_i && // R19
      reg_wdata_i[2:0] == sst_pkg::ACT_IDLE |=> st.fsm == sst_pkg::SST_IDLE)
      else $error("idle action did not stop the field counter");
   a_after_gate: assert property (st.pline |-> // R5
      {1'b0, st.lc} >= {1'b0, st.gate_line} + 14'h0001)
      else $error("pulse line at or before gate line");
   a_toggle_load: assert property ($past(rst_n_i) && $changed(st.t1) |-> // R6
      $past(upd && clk_en_i))
      else $error("toggle changed outside update line");
endmodule

// *** testbench/sst_ccd_model.sv ***
module sst_ccd_model (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic line_sync_i,
   input  wire logic field_sync_i,
   input  wire logic shutter_i,
   input  wire logic gate_i,
   output integer    hi_o,
   output integer    rise_o,
   output integer    first_o,
   output integer    gate_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // per-field tallies of what reaches the substrate and the gate
   // ----------------------------------------------------------------
   // whole-field windows, so the output lag of the block cancels out
   // four-state tallies, so an unknown output cannot count as zero
   integer hi, rise, first, gate;
   int     ln;
   bit     prev;
   wire up = shutter_i && !prev;
   always @(posedge core_clk_i) begin
      prev <= shutter_i;
      if (!rst_n_i || field_sync_i) begin
         hi_o    <= hi;
         rise_o  <= rise;
         first_o <= first;
         gate_o  <= gate;
         hi      <= shutter_i;
         rise    <= up;
         first   <= up ? 0 : 99;
         gate    <= gate_i;
         ln      <= 0;
      end else begin
         hi   <= hi + shutter_i;
         rise <= rise + up;
         gate <= gate + gate_i;
         if (up && first == 99) first <= ln;
         if (line_sync_i) ln <= ln + 1;
      end
   end
endmodule

// *** testbench/test_substrate_shutter_timing.sv ***
module test_substrate_shutter_timing;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, reg_wr, reg_rd, sub, sg;
   logic        drv = 1'b0;
   logic        sel = 1'b0;
   logic        en  = 1'b1;
   logic [9:0]  addr;
   logic [31:0] wdata, rdata, rv;
   logic [31:0] seed = 32'h00000023;
   logic [1:0]  lvl, el;
   logic [5:0]  pix;
   logic [3:0]  ln;
   bit          ok;
   integer      hi, ri, fi, ga;
   int          miscompares, checks, st, f, act, g, s, sk;
   // table row 0 is the reset setting; hp on means extra pulse [30,40)
   int tn[5] = '{1, 0, 1, 2, 3};
   int td[5] = '{0, 0, 2, 0, 0};
   int tp[5] = '{0, 0, 0, 1, 0};
   int ta[5] = '{0, 8, 8, 5, 8};
   int tb[5] = '{0, 20, 20, 9, 20};
   int th[5] = '{0, 0, 1, 0, 0};
   wire lsync = rst_n && pix == 6'h00;
   wire fsync = lsync && ln == 4'h0;
   wire sreq  = ln == 4'h2 && pix >= 6'h0a && pix < 6'h14;

   sst_shutter sst_shutter_inst (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
      .line_sync_i(lsync), .field_sync_i(fsync), .sense_gate_req_i(sreq),
      .substrate_driver_input_i(drv), .substrate_level_select_input_i(sel),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(rdata), .substrate_shutter_pulse_o(sub), .sense_gate_pulse_o(sg),
      .substrate_level_o(lvl));
   sst_ccd_model sst_ccd_model_inst (.core_clk_i(clk), .rst_n_i(rst_n), .line_sync_i(lsync),
      .field_sync_i(fsync), .shutter_i(sub), .gate_i(sg), .hi_o(hi), .rise_o(ri),
      .first_o(fi), .gate_o(ga));

   // ----------------------------------------------------------------
   // clock, line timing, random driver bits
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         pix <= 6'h00;
         ln  <= 4'h0;
      end else begin
         pix <= pix + 6'h01;
         if (pix == 6'h3f) ln <= ln + 4'h1;
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   always @(posedge clk) begin
      seed = xs(seed);
      drv <= seed[0];
      sel <= seed[1];
      if (en) el <= drv ? (sel ? sst_pkg::LVL_LOWEST : sst_pkg::LVL_MID_LOW) : sst_pkg::LVL_HIGH;
      ok  <= rst_n;
   end
   always @(negedge clk) if (ok) chk("level", 32'(lvl), 32'(el));

   // ----------------------------------------------------------------
   // bus tasks, field model, checks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      addr   <= {idx, 2'b00};
      wdata  <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      @(posedge clk);
      addr   <= {idx, 2'b00};
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic at_line(input int n);
      while (!(ln == n && pix == 6'h08)) @(posedge clk);
   endtask
   function automatic int ew(input int k);
      return (tb[k] - ta[k]) * tn[k] + ((th[k] != 0 && tn[k] > 0) ? 10 : 0);
   endfunction
   task automatic fld_end(input bit cmp, input int k);
      int  e, w;
      bit  gm, sm;
      @(posedge clk);
      while (!fsync) @(posedge clk);
      repeat (3) @(posedge clk);
      #1 e = f - sk;
      gm = st == 2 && e >= 1 && e <= g;
      sm = st == 2 && e >= 1 && e <= s;
      w  = sm ? 0 : ew(k);
      if (cmp) begin
         chk("shutter_high", 32'(hi), 32'(tp[k] ? 1024 - w : w));
         chk("shutter_edges", 32'(ri), 32'(w ? tn[k] + (th[k] && tn[k]) : 0));
         chk("first_line", 32'(fi), 32'(w ? 3 + td[k] : 99));
         chk("gate_cycles", 32'(ga), 32'(gm ? 0 : 10));
      end
      if (st == 1) begin
         st = 2;
         f  = 1;
      end else if (st == 2 && f >= (g > s ? g : s) + sk) begin
         if (act == 1) st = 0;
         else f = 1;
      end else if (st == 2) f++;
   endtask
   // long mode for multi-field exposure, skip bit in place of a delay count
   task automatic ls(input int gg, input int ss, input int aa, input int nf);
      at_line(12);
      wr(sst_pkg::IDX_MASKS, 32'((ss << 16) | gg));
      wr(sst_pkg::IDX_CTRL, 32'h00000002);
      wr(sst_pkg::IDX_ACTION, 32'(aa));
      g   = gg;
      s   = ss;
      act = aa;
      sk  = 1;
      st  = 1;
      repeat (nf) fld_end(1, 4);
   endtask
   task automatic wrap_up;
      $display("miscompares=%0d checks=%0d", miscompares, checks);
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      rst_n  = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      addr   = 10'h000;
      wdata  = 32'h00000000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(sst_pkg::IDX_PCOUNT, rv);
      chk("pcount_reset", rv, 32'(sst_pkg::PCOUNT_RESET));
      rd(sst_pkg::IDX_FINE, rv);
      chk("fine_reset", rv, 32'(sst_pkg::HP_OFF));
      rd(sst_pkg::IDX_ACTION, rv);
      chk("action_reset", rv, 32'h00000000);
      rd(8'hff, rv);
      chk("unmapped", rv, 32'h00000000);
      // a read strobe on a frozen edge is not taken, read data keep their idle zero
      @(posedge clk);
      en     <= 1'b0;
      addr   <= {sst_pkg::IDX_PCOUNT, 2'b00};
      reg_rd <= 1'b1;
      @(posedge clk);
      en     <= 1'b1;
      reg_rd <= 1'b0;
      #1 chk("frozen_read", rdata, 32'h00000000);
      wr(sst_pkg::IDX_GLINE, 32'h00000002);
      for (int i = 1; i < 5; i++) begin
         at_line(4);
         wr(sst_pkg::IDX_TOGGLE, 32'((tb[i] << 16) | ta[i]));
         wr(sst_pkg::IDX_PCOUNT, 32'(tn[i]));
         wr(sst_pkg::IDX_DELAY, 32'(td[i]));
         wr(sst_pkg::IDX_CTRL, 32'(tp[i]));
         at_line(12);
         wr(sst_pkg::IDX_FINE, th[i] ? 32'((40 << 14) | 30) : 32'(sst_pkg::HP_OFF));
         fld_end(1, i - 1);
         fld_end(0, i);
         fld_end(1, i);
      end
      rd(sst_pkg::IDX_PCOUNT, rv);
      chk("pcount", rv, 32'h00000003);
      ls(1, 2, 1, 5);
      ls(0, 0, 2, 3);
      rd(sst_pkg::IDX_STATUS, rv);
      chk("run_active", 32'(rv[sst_pkg::STAT_RUN_BIT]), 32'h00000001);
      wr(sst_pkg::IDX_ACTION, 32'(sst_pkg::ACT_IDLE));
      rd(sst_pkg::IDX_STATUS, rv);
      chk("run_stopped", 32'(rv[sst_pkg::STAT_RUN_BIT]), 32'h00000000);
      wrap_up();
   end
   initial begin
      #300000;
      miscompares++;
      wrap_up();
   end
endmodule
